// ### common/pmr_pkg.sv
/*
 * pmr_pkg: register offsets, field positions, reset values, frame
 * constants, state codes and carrier structs of the management bank.
 * Assumes one clock domain; the management pins are sampled inside it.
 */
package pmr_pkg;

  // base map offsets (5-bit register address)
  localparam logic [4:0] RA_BASE_CONTROL    = 5'h00;
  localparam logic [4:0] RA_BASE_STATUS     = 5'h01;
  localparam logic [4:0] RA_IDENT_HI        = 5'h02;
  localparam logic [4:0] RA_IDENT_LO        = 5'h03;
  localparam logic [4:0] RA_AUTONEG_ADVERT  = 5'h04;
  localparam logic [4:0] RA_NEXT_PAGE_RX    = 5'h08;
  localparam logic [4:0] RA_NEXT_PAGE_TX    = 5'h07;
  localparam logic [4:0] RA_GIG_CONTROL     = 5'h09;
  localparam logic [4:0] RA_GIG_STATUS      = 5'h0A;
  localparam logic [4:0] RA_GIG_EXT_STATUS  = 5'h0F;
  localparam logic [4:0] RA_PIN_OPTION      = 5'h10;
  localparam logic [4:0] RA_CAPABILITY      = 5'h11;
  localparam logic [4:0] RA_CROSSOVER_SEL   = 5'h15;
  localparam logic [4:0] RA_INDIRECT_CTRL   = 5'h16;
  localparam logic [4:0] RA_INDIRECT_DATA   = 5'h1D;
  localparam logic [4:0] RA_INDIRECT_PTR    = 5'h1E;

  // extended map offsets
  localparam logic [15:0] XA_IRQ_STATUS_0   = 16'h810D;
  localparam logic [15:0] XA_IRQ_STATUS_1   = 16'h810E;
  localparam logic [15:0] XA_IRQ_CAUSE_0    = 16'h810F;
  localparam logic [15:0] XA_IRQ_CAUSE_1    = 16'h8110;
  localparam logic [15:0] XA_IRQ_RAW_0      = 16'h8111;
  localparam logic [15:0] XA_IRQ_RAW_1      = 16'h8112;
  localparam logic [15:0] XA_IRQ_ENABLE_0   = 16'h8113;
  localparam logic [15:0] XA_IRQ_ENABLE_1   = 16'h8114;
  localparam logic [15:0] XA_IRQ_CLEAR_0    = 16'h8115;
  localparam logic [15:0] XA_IRQ_CLEAR_1    = 16'h8116;
  localparam logic [15:0] XA_LAST_RW        = 16'h811A;
  localparam int          XRW_SLOTS         = 8;

  // base_control fields
  localparam int BC_RESET      = 15;
  localparam int BC_LOOPBACK   = 14;
  localparam int BC_SPEED0     = 13;
  localparam int BC_AN_EN      = 12;
  localparam int BC_POWER_DOWN = 11;
  localparam int BC_ISOLATE    = 10;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_DUPLEX     = 8;
  localparam int BC_COL_TEST   = 7;
  localparam int BC_SPEED1     = 6;

  // base_status dynamic fields
  localparam int BS_AN_DONE    = 5;
  localparam int BS_RFAULT     = 4;
  localparam int BS_LINK       = 2;
  localparam int BS_JABBER     = 1;

  // pin_option_latch: strapped station address position
  localparam int PO_ADDR_LO    = 6;

  // reset and fixed values
  localparam logic [15:0] BASE_STATUS_FIXED  = 16'h6149;
  localparam logic [15:0] RST_AUTONEG_ADVERT = 16'h8181;
  localparam logic [15:0] RST_NEXT_PAGE_TX   = 16'hA008;
  localparam logic [15:0] RST_ZERO           = 16'h0000;

  // management frame
  localparam logic [4:0] PRE_LAST  = 5'h1F;  // 32 ones
  localparam logic [4:0] HDR_LAST  = 5'h0B;  // op + station + register
  localparam logic [4:0] TA_LAST   = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] OP_READ   = 2'b10;
  localparam logic [1:0] OP_WRITE  = 2'b01;

  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_IDLE  = 3'b001,
    ST_START = 3'b011,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b110,
    ST_DATA  = 3'b111
  } pmr_state_t;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] station;
    logic [4:0] reg_addr;
  } pmr_hdr_t;

  typedef struct packed {
    logic       speed0;
    logic       an_enable;
    logic       duplex;
    logic       speed1;
    logic [4:0] station;
  } pmr_strap_t;

  typedef struct packed {
    logic       loopback;
    logic       power_down;
    logic       isolate;
    logic       an_enable;
    logic       an_restart;
    logic       duplex;
    logic [1:0] speed;
    logic       col_test;
  } pmr_ctrl_t;

endpackage

// ### core/pmr_core.sv
/*
 * pmr_core: management register bank with its serial management slave.
 * Assumes mdc/mdio/strap pins are asynchronous (two-flop synchronised),
 * event inputs come from logic on the same clock, and mdc is much
 * slower than clock (at least four clock periods per mdc phase).
 */
// Functional notes
// - base_control at 0x00 decoded, readable and writable.
// - base_status at 0x01 read-only; writes change nothing.
// - ident_hi/ident_lo at 0x02/0x03 read-only fixed identity.
// - auto-negotiation registers 0x04 to 0x08 readable and writable.
// - gig_control 0x09 writable; gig_status 0x0A, gig_ext_status 0x0F read-only.
// - irq status, cause, raw cause pairs 0x810D-0x8112 read-only.
// - irq_enable pair at 0x8113/0x8114 readable and writable.
// - irq_clear pair at 0x8115/0x8116 readable and writable.
// - latched bits set on event, hold until their register is read.
// - self-clearing bits set by a write; reset drops next cycle, restart on an_restart_done.
// - fixed bits always read default; writes ignored.
// - strap bits take reset value from pin level sampled in reset.
// - management frames answered even while isolate is set.
`timescale 1ns/1ps
`default_nettype none

module pmr_core
  import pmr_pkg::*;
#(
  parameter logic [15:0] ID_HI          = 16'h0A5C,  // arbitrary value
  parameter logic [15:0] ID_LO          = 16'h5C31,  // arbitrary value
  parameter logic [15:0] GIG_EXT_STATUS = 16'h3000,
  parameter logic [15:0] CAPABILITY     = 16'h0000
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire pmr_strap_t  strap_pins,
  input  wire logic        link_up,
  input  wire logic        an_complete,
  input  wire logic        remote_fault,
  input  wire logic        jabber,
  input  wire logic        an_restart_done,
  input  wire logic [15:0] gig_status_in,
  input  wire logic [31:0] irq_event,
  output pmr_ctrl_t        ctrl_out,
  output logic             soft_reset,
  output logic [4:0]       station_addr,
  output logic [15:0]      crossover_out,
  output logic [31:0]      irq_active
);

  // pin synchronisers
  logic       mdc_s1_reg, mdc_s2_reg, mdc_d_reg;
  logic       mdio_s1_reg, mdio_s2_reg;
  pmr_strap_t strap_s1_reg, strap_s2_reg, strap_reg;

  // frame engine
  pmr_state_t state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [10:0] hdr_sr_reg;
  pmr_hdr_t    hdr_reg;
  logic        hit_reg;
  logic [15:0] sr_reg;
  logic        mdio_out_reg, mdio_oe_reg;

  // register storage
  logic [15:0] base_rw_reg [32];
  logic [15:0] ext_rw_reg [XRW_SLOTS];
  logic [31:0] cause_reg;
  logic        link_lat_reg, jab_lat_reg, rf_lat_reg;

  // decode wires
  logic        mdc_rise, bit_in;
  pmr_hdr_t    hdr_now;
  logic        op_ok, rd_take, wr_take, in_hdr_end;
  logic [15:0] wr_data, rd_data, ext_rd, ptr;
  logic [4:0]  wr_addr;
  logic        bank_rst, ext_rw_hit, status_read;
  logic [2:0]  ext_slot;
  pmr_strap_t  strap_src;
  logic [31:0] cause_clr;

  // writable base offsets; everything else drops writes
  function automatic logic base_writable(input logic [4:0] a);
    return (a == RA_BASE_CONTROL) ||
           (a >= RA_AUTONEG_ADVERT && a <= RA_GIG_CONTROL) ||
           (a == RA_PIN_OPTION) || (a == RA_CROSSOVER_SEL) ||
           (a == RA_INDIRECT_CTRL) || (a == RA_INDIRECT_PTR);
  endfunction

  // reset image of a base register, shared by hard and soft reset
  function automatic logic [15:0] base_default(input logic [4:0] a,
                                               input pmr_strap_t s);
    logic [15:0] v;
    v = RST_ZERO;
    unique case (a)
      RA_BASE_CONTROL:
      begin
        v[BC_SPEED0] = s.speed0;
        v[BC_AN_EN]  = s.an_enable;
        v[BC_DUPLEX] = s.duplex;
        v[BC_SPEED1] = s.speed1;
      end
      RA_AUTONEG_ADVERT: v = RST_AUTONEG_ADVERT;
      RA_NEXT_PAGE_TX:   v = RST_NEXT_PAGE_TX;
      RA_PIN_OPTION:     v[PO_ADDR_LO +: 5] = s.station;
      default:           v = RST_ZERO;
    endcase
    return v;
  endfunction

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock)
  begin
    mdc_s1_reg   <= mdc;
    mdc_s2_reg   <= mdc_s1_reg;
    mdc_d_reg    <= mdc_s2_reg;
    mdio_s1_reg  <= mdio_in;
    mdio_s2_reg  <= mdio_s1_reg;
    strap_s1_reg <= strap_pins;
    strap_s2_reg <= strap_s1_reg;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      strap_reg <= strap_s2_reg;
  end

  // frame decode
  assign mdc_rise   = mdc_s2_reg & ~mdc_d_reg;
  assign bit_in     = mdio_s2_reg;
  assign hdr_now    = {hdr_sr_reg, bit_in};
  assign op_ok      = (hdr_now.op == OP_READ) || (hdr_now.op == OP_WRITE);
  assign in_hdr_end = mdc_rise && (state_reg == ST_HDR) && (cnt_reg == HDR_LAST);
  assign rd_take    = in_hdr_end && (hdr_now.op == OP_READ) &&
                      (hdr_now.station == strap_reg.station);
  assign wr_take    = mdc_rise && (state_reg == ST_DATA) && (cnt_reg == DATA_LAST) &&
                      (hdr_reg.op == OP_WRITE) && hit_reg;
  assign wr_data    = {sr_reg[14:0], bit_in};
  assign wr_addr    = hdr_reg.reg_addr;

  // next state of the frame engine
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (mdc_rise)
    begin
      unique case (state_reg)
        ST_PRE:
        begin
          cnt_next = bit_in ? cnt_reg + 5'h01 : 5'h00;
          if (bit_in && cnt_reg == PRE_LAST)
            state_next = ST_IDLE;
        end
        // preamble suppressed once synchronised
        ST_IDLE:  if (!bit_in) state_next = ST_START;
        ST_START:
        begin
          cnt_next   = 5'h00;
          state_next = bit_in ? ST_HDR : ST_PRE;
        end
        ST_HDR:
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == HDR_LAST)
          begin
            cnt_next   = 5'h00;
            state_next = op_ok ? ST_TA : ST_PRE;  // bad opcode: resync
          end
        end
        ST_TA:
        begin
          cnt_next = cnt_reg + 5'h01;
          // write turnaround must be 1 then 0
          if (hdr_reg.op == OP_WRITE && bit_in == (cnt_reg == TA_LAST))
            state_next = ST_PRE;
          else if (cnt_reg == TA_LAST)
          begin
            cnt_next   = 5'h00;
            state_next = ST_DATA;
          end
        end
        ST_DATA:
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == DATA_LAST)
            state_next = ST_IDLE;
        end
        default:
        begin
          cnt_next   = 5'h00;
          state_next = ST_PRE;
        end
      endcase
    end
  end

  // frame engine state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_PRE;
      cnt_reg   <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // header shift and latch
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hdr_sr_reg <= 11'h000;
      hdr_reg    <= '0;
      hit_reg    <= 1'b0;
    end
    else if (mdc_rise && state_reg == ST_HDR)
    begin
      hdr_sr_reg <= hdr_now[10:0];
      if (cnt_reg == HDR_LAST)
      begin
        hdr_reg <= hdr_now;
        hit_reg <= hdr_now.station == strap_reg.station;
      end
    end
  end

  // data shifter and pin drive; read data loaded at header end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sr_reg       <= 16'h0000;
      mdio_out_reg <= 1'b0;
      mdio_oe_reg  <= 1'b0;
    end
    else if (rd_take)
      sr_reg <= rd_data;
    else if (mdc_rise)
    begin
      if (state_reg == ST_TA && hdr_reg.op == OP_READ && hit_reg && cnt_reg != TA_LAST)
      begin
        mdio_oe_reg  <= 1'b1;  // second turnaround bit driven low
        mdio_out_reg <= 1'b0;
      end
      else if (mdio_oe_reg && !(state_reg == ST_DATA && cnt_reg == DATA_LAST))
      begin
        mdio_out_reg <= sr_reg[15];
        sr_reg       <= {sr_reg[14:0], 1'b0};
      end
      else
      begin
        mdio_oe_reg <= 1'b0;
        if (state_reg == ST_DATA)
          sr_reg <= {sr_reg[14:0], bit_in};
      end
    end
  end

  assign mdio_out = mdio_out_reg;
  assign mdio_oe  = mdio_oe_reg;

  assign ptr        = base_rw_reg[RA_INDIRECT_PTR];
  assign ext_rw_hit = (ptr >= XA_IRQ_ENABLE_0) && (ptr <= XA_LAST_RW);
  assign ext_slot   = 3'(ptr - XA_IRQ_ENABLE_0);

  always_comb
  begin
    ext_rd = RST_ZERO;
    if (ext_rw_hit)
      ext_rd = ext_rw_reg[ext_slot];
    else
    begin
      unique case (ptr)
        XA_IRQ_STATUS_0: ext_rd = cause_reg[15:0] & ext_rw_reg[0];
        XA_IRQ_STATUS_1: ext_rd = cause_reg[31:16] & ext_rw_reg[1];
        XA_IRQ_CAUSE_0:  ext_rd = cause_reg[15:0];
        XA_IRQ_CAUSE_1:  ext_rd = cause_reg[31:16];
        XA_IRQ_RAW_0:    ext_rd = irq_event[15:0];
        XA_IRQ_RAW_1:    ext_rd = irq_event[31:16];
        default:         ext_rd = RST_ZERO;
      endcase
    end
  end

  // base read mux
  always_comb
  begin
    rd_data = RST_ZERO;
    unique case (hdr_now.reg_addr)
      RA_BASE_STATUS:
      begin
        rd_data             = BASE_STATUS_FIXED;
        rd_data[BS_AN_DONE] = an_complete;
        rd_data[BS_RFAULT]  = rf_lat_reg;
        rd_data[BS_LINK]    = link_lat_reg;
        rd_data[BS_JABBER]  = jab_lat_reg;
      end
      RA_IDENT_HI:       rd_data = ID_HI;
      RA_IDENT_LO:       rd_data = ID_LO;
      RA_GIG_STATUS:     rd_data = gig_status_in;
      RA_GIG_EXT_STATUS: rd_data = GIG_EXT_STATUS;
      RA_CAPABILITY:     rd_data = CAPABILITY;
      RA_INDIRECT_DATA:  rd_data = ext_rd;
      default:
        rd_data = base_writable(hdr_now.reg_addr) ? base_rw_reg[hdr_now.reg_addr] : RST_ZERO;
    endcase
  end

  // hard reset or the self-clearing reset bit
  assign bank_rst  = sys_rst | base_rw_reg[RA_BASE_CONTROL][BC_RESET];
  assign strap_src = sys_rst ? strap_s2_reg : strap_reg;

  always_ff @(posedge clock)
  begin
    if (bank_rst)
    begin
      for (int i = 0; i < 32; i++)
        base_rw_reg[i] <= base_default(5'(i), strap_src);
    end
    else
    begin
      if (an_restart_done)
        base_rw_reg[RA_BASE_CONTROL][BC_AN_RESTART] <= 1'b0;
      if (wr_take && base_writable(wr_addr))
        base_rw_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (bank_rst)
    begin
      for (int i = 0; i < XRW_SLOTS; i++)
        ext_rw_reg[i] <= RST_ZERO;
    end
    else if (wr_take && wr_addr == RA_INDIRECT_DATA && ext_rw_hit)
      ext_rw_reg[ext_slot] <= wr_data;
  end

  assign status_read = rd_take && hdr_now.reg_addr == RA_BASE_STATUS;
  always_comb
  begin
    cause_clr = 32'h0000_0000;
    if (rd_take && hdr_now.reg_addr == RA_INDIRECT_DATA)
    begin
      if (ptr == XA_IRQ_CAUSE_0) cause_clr[15:0]  = 16'hFFFF;
      if (ptr == XA_IRQ_CAUSE_1) cause_clr[31:16] = 16'hFFFF;
    end
    if (wr_take && wr_addr == RA_INDIRECT_DATA)
    begin
      if (ptr == XA_IRQ_CLEAR_0) cause_clr[15:0]  = wr_data;
      if (ptr == XA_IRQ_CLEAR_1) cause_clr[31:16] = wr_data;
    end
  end

  // sticky causes; a new event beats the clear
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cause_reg <= 32'h0000_0000;
    else
      cause_reg <= (cause_reg & ~cause_clr) | irq_event;
  end

  // latched status bits, refreshed from live levels on read
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      link_lat_reg <= 1'b0;
      jab_lat_reg  <= 1'b0;
      rf_lat_reg   <= 1'b0;
    end
    else if (status_read)
    begin
      link_lat_reg <= link_up;
      jab_lat_reg  <= jabber;
      rf_lat_reg   <= remote_fault;
    end
    else
    begin
      link_lat_reg <= link_lat_reg & link_up;  // holds a link drop
      jab_lat_reg  <= jab_lat_reg | jabber;
      rf_lat_reg   <= rf_lat_reg | remote_fault;
    end
  end

  // control outputs straight from stored bits
  assign ctrl_out.loopback   = base_rw_reg[RA_BASE_CONTROL][BC_LOOPBACK];
  assign ctrl_out.power_down = base_rw_reg[RA_BASE_CONTROL][BC_POWER_DOWN];
  assign ctrl_out.isolate    = base_rw_reg[RA_BASE_CONTROL][BC_ISOLATE];
  assign ctrl_out.an_enable  = base_rw_reg[RA_BASE_CONTROL][BC_AN_EN];
  assign ctrl_out.an_restart = base_rw_reg[RA_BASE_CONTROL][BC_AN_RESTART];
  assign ctrl_out.duplex     = base_rw_reg[RA_BASE_CONTROL][BC_DUPLEX];
  assign ctrl_out.speed      = {base_rw_reg[RA_BASE_CONTROL][BC_SPEED1],
                                base_rw_reg[RA_BASE_CONTROL][BC_SPEED0]};
  assign ctrl_out.col_test   = base_rw_reg[RA_BASE_CONTROL][BC_COL_TEST];
  // reset bit is high one cycle
  assign soft_reset          = base_rw_reg[RA_BASE_CONTROL][BC_RESET];
  assign station_addr        = strap_reg.station;
  assign crossover_out       = base_rw_reg[RA_CROSSOVER_SEL];
  assign irq_active          = cause_reg & {ext_rw_reg[1], ext_rw_reg[0]};

endmodule // pmr_core

`default_nettype wire

// ### dv/pmr_core_properties.sv
/*
 * pmr_core_properties: port-level assertions of the management bank.
 * Assumes it is bound onto pmr_core and that each mdc phase lasts four clocks or more.
 */
`timescale 1ns/1ps
`default_nettype none

module pmr_core_properties
  import pmr_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        mdc,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire pmr_strap_t  strap_pins,
  input wire logic        an_restart_done,
  input wire pmr_ctrl_t   ctrl_out,
  input wire logic        soft_reset,
  input wire logic [4:0]  station_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // strapped images must be in place just after reset release
  a_strap_image: assert property ($fell(sys_rst) |-> ##[0:2] (station_addr == strap_pins.station
    && ctrl_out.an_enable == strap_pins.an_enable && ctrl_out.duplex == strap_pins.duplex
    && ctrl_out.speed == {strap_pins.speed1, strap_pins.speed0}))
    else $error("strap image wrong after reset");
  a_soft_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  a_soft_defaults: assert property (soft_reset |-> ##[0:1] (!ctrl_out.loopback
    && !ctrl_out.isolate && !ctrl_out.power_down && ctrl_out.duplex == strap_pins.duplex))
    else $error("soft reset left control bits set");
  // a read answer starts with the zero turnaround bit
  a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_out_on_mdc: assert property (mdio_oe && $changed(mdio_out) |-> mdc)
    else $error("read data changed while mdc low");
  a_oe_holds: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
    else $error("read drive dropped early");
  a_oe_edges: assert property (($rose(mdio_oe) || $fell(mdio_oe)) |-> mdc)
    else $error("drive enable moved while mdc low");
  // control only moves on a frame write or a restart completion
  a_ctrl_on_frame: assert property ($changed(ctrl_out) |-> mdc || an_restart_done
    || $past(an_restart_done))
    else $error("control changed without a frame");

endmodule // pmr_core_properties

`default_nettype wire

// ### dv/pmr_sta_model.sv
/*
 * pmr_sta_model: station management controller sending whole frames on mdc/mdio.
 * Assumes the bench resolves mdio from both enables with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module pmr_sta_model
  import pmr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [4:0] station,
  input  wire logic       mdio_wire,
  output var logic        mdc,
  output var logic        mdio_drv,
  output var logic        mdio_en
);
  // mdc starts low and is left high after each frame; the line is released outside frames
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
  end

  // one mdc period of nine clocks; the wire is sampled at the rise
  task automatic cyc(input logic d, input logic en, output logic s);
    @(posedge clock);
    mdc <= 1'b0;
    mdio_drv <= d;
    mdio_en <= en;
    repeat (4) @(posedge clock);
    mdc <= 1'b1;
    s = mdio_wire;
    repeat (4) @(posedge clock);
  endtask

  // preamble always sent: slower, but resync never depends on history
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        wrop;
    wrop = (op != OP_READ);
    hdr = {2'b01, op, station, ra};
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(hdr[i], 1'b1, s);
    cyc(1'b1, wrop, s);
    cyc(1'b0, wrop, s);
    for (int i = 15; i >= 0; i--)
    begin
      cyc(wd[i], wrop, s);
      rd[i] = s;
    end
    cyc(1'b1, 1'b0, s);
  endtask

endmodule // pmr_sta_model

`default_nettype wire

// ### dv/phy_mgmt_register_map_tb.sv
/*
 * phy_mgmt_register_map_tb: self-checking bench of the management bank.
 * Assumes the station model and a pull-up on mdio; one 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module phy_mgmt_register_map_tb
  import pmr_pkg::*;
;
  localparam logic [15:0] TB_ID_HI = 16'h1357;  // arbitrary value
  localparam logic [15:0] TB_ID_LO = 16'h2468;  // arbitrary value
  localparam logic [15:0] TB_EXT   = 16'h3000;
  localparam logic [15:0] TB_CAP   = 16'h0000;

  logic        clock, sys_rst, mdc, mdio_wire, mdio_out, mdio_oe, sta_drv, sta_en;
  logic        link_up, an_complete, remote_fault, jabber, an_restart_done, soft_reset;
  pmr_strap_t  strap;
  pmr_ctrl_t   ctrl_out;
  logic [4:0]  station_addr;
  logic [15:0] gig_status_in, crossover_out, w;
  logic [31:0] irq_event, irq_active, e;
  int          n_fail, n_checks;
  logic [4:0]  rw_list [7] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h15};
  logic [4:0]  ro_list [6] = '{5'h02, 5'h0A, 5'h0F, 5'h0B, 5'h14, 5'h1F};

  // pull-up wins only when nobody drives
  assign mdio_wire = mdio_oe ? mdio_out : (sta_en ? sta_drv : 1'b1);

  always #20 clock = ~clock;

  pmr_core #(.ID_HI(TB_ID_HI), .ID_LO(TB_ID_LO), .GIG_EXT_STATUS(TB_EXT), .CAPABILITY(TB_CAP))
  i_dut (
    .clock(clock), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .strap_pins(strap), .link_up(link_up), .an_complete(an_complete),
    .remote_fault(remote_fault), .jabber(jabber), .an_restart_done(an_restart_done),
    .gig_status_in(gig_status_in), .irq_event(irq_event), .ctrl_out(ctrl_out),
    .soft_reset(soft_reset), .station_addr(station_addr), .crossover_out(crossover_out),
    .irq_active(irq_active)
  );

  pmr_sta_model i_sta (
    .clock(clock), .station(strap.station), .mdio_wire(mdio_wire), .mdc(mdc),
    .mdio_drv(sta_drv), .mdio_en(sta_en)
  );

  function automatic logic [15:0] exp_ctrl(pmr_strap_t s);
    logic [15:0] r;
    r = 16'h0000;
    r[BC_SPEED0] = s.speed0;
    r[BC_AN_EN] = s.an_enable;
    r[BC_DUPLEX] = s.duplex;
    r[BC_SPEED1] = s.speed1;
    return r;
  endfunction

  function automatic logic [15:0] exp_ro(logic [4:0] ra);
    case (ra)
      RA_IDENT_HI:       return TB_ID_HI;
      RA_GIG_STATUS:     return gig_status_in;
      RA_GIG_EXT_STATUS: return TB_EXT;
      default:           return 16'h0000;
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    i_sta.frame(OP_WRITE, ra, d, unused);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] ra, input logic [15:0] ex);
    logic [15:0] got;
    i_sta.frame(OP_READ, ra, 16'h0000, got);
    chk(name, 32'(ex), 32'(got));
  endtask

  // pointer first, then the data window
  task automatic xwr(input logic [15:0] xa, input logic [15:0] d);
    wr(RA_INDIRECT_PTR, xa);
    wr(RA_INDIRECT_DATA, d);
  endtask

  task automatic xrd(input string name, input logic [15:0] xa, input logic [15:0] ex);
    wr(RA_INDIRECT_PTR, xa);
    rd_chk(name, RA_INDIRECT_DATA, ex);
  endtask

  // new random straps each time; station drawn from 1 to 31, so zero is never used
  task automatic reset_check();
    @(posedge clock);
    sys_rst <= 1'b1;
    strap <= {4'($urandom), 5'($urandom_range(31, 1))};
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk("autoneg_advert", RA_AUTONEG_ADVERT, RST_AUTONEG_ADVERT);
    rd_chk("next_page_tx", RA_NEXT_PAGE_TX, RST_NEXT_PAGE_TX);
    rd_chk("pin_option_latch", RA_PIN_OPTION, 16'(strap.station) << PO_ADDR_LO);
    rd_chk("base_control", RA_BASE_CONTROL, exp_ctrl(strap));
    rd_chk("ident_lo", RA_IDENT_LO, TB_ID_LO);
    rd_chk("capability", RA_CAPABILITY, TB_CAP);
    chk("station_addr", 32'(strap.station), 32'(station_addr));
    $display("test reset and straps done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (90000) @(posedge clock);
    n_fail++;
    results();
  end

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    strap = '0;
    {link_up, an_complete, remote_fault, jabber, an_restart_done} = 5'h18;
    gig_status_in = 16'h0000;
    irq_event = 32'h0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'h8a0d));
    reset_check();
    for (int k = 0; k < 7; k++)
    begin
      w = 16'($urandom);
      wr(rw_list[k], w);
      rd_chk("rw_reg", rw_list[k], w);
    end
    chk("crossover_out", 32'(w), 32'(crossover_out));
    $display("test read-write done");
    @(posedge clock);
    gig_status_in <= 16'($urandom);
    for (int k = 0; k < 6; k++)
    begin
      wr(ro_list[k], 16'($urandom));
      rd_chk("ro_reg", ro_list[k], exp_ro(ro_list[k]));
    end
    $display("test read-only done");
    // latched bits hold until read
    // link latched low since reset, refreshed by this read
    rd_chk("base_status", RA_BASE_STATUS, BASE_STATUS_FIXED | 16'h0020);
    rd_chk("base_status", RA_BASE_STATUS, BASE_STATUS_FIXED | 16'h0024);
    @(posedge clock);
    {link_up, remote_fault, jabber} <= 3'b011;
    repeat (3) @(posedge clock);
    {link_up, remote_fault, jabber} <= 3'b100;
    rd_chk("base_status", RA_BASE_STATUS, BASE_STATUS_FIXED | 16'h0032);
    wr(RA_BASE_STATUS, 16'hFFFF);
    rd_chk("base_status", RA_BASE_STATUS, BASE_STATUS_FIXED | 16'h0024);
    $display("test latched status done");
    // isolate keeps the link answering; soft reset restores
    w = (16'($urandom) & 16'h7DC0) | 16'h0600;
    wr(RA_BASE_CONTROL, w);
    rd_chk("base_control", RA_BASE_CONTROL, w);
    chk("isolate", 1, 32'(ctrl_out.isolate));
    rd_chk("ident_hi", RA_IDENT_HI, TB_ID_HI);
    // restart bit must drop once negotiation reports done
    @(posedge clock);
    an_restart_done <= 1'b1;
    @(posedge clock);
    an_restart_done <= 1'b0;
    rd_chk("base_control", RA_BASE_CONTROL, w & 16'hFDFF);
    wr(RA_BASE_CONTROL, 16'h8000);
    rd_chk("base_control", RA_BASE_CONTROL, exp_ctrl(strap));
    chk("crossover_out", 0, 32'(crossover_out));
    $display("test control done");
    for (int k = 0; k < XRW_SLOTS; k++)
    begin
      w = 16'($urandom);
      xwr(XA_IRQ_ENABLE_0 + 16'(k), w);
      xrd("ext_rw", XA_IRQ_ENABLE_0 + 16'(k), w);
    end
    $display("test extended storage done");
    e = $urandom | 32'h0001_0001;
    @(posedge clock);
    irq_event <= e;
    xrd("irq_raw_0", XA_IRQ_RAW_0, e[15:0]);
    xrd("irq_raw_1", XA_IRQ_RAW_1, e[31:16]);
    @(posedge clock);
    irq_event <= 32'h0;
    xwr(XA_IRQ_ENABLE_0, 16'hFFFF);
    xwr(XA_IRQ_ENABLE_1, 16'h0000);
    chk("irq_active", {16'h0000, e[15:0]}, irq_active);
    xrd("irq_status_0", XA_IRQ_STATUS_0, e[15:0]);
    xrd("irq_cause_1", XA_IRQ_CAUSE_1, e[31:16]);
    xrd("irq_cause_1", XA_IRQ_CAUSE_1, 16'h0000);
    xwr(XA_IRQ_CLEAR_0, e[15:0]);
    xrd("irq_cause_0", XA_IRQ_CAUSE_0, 16'h0000);
    chk("irq_active", 0, irq_active);
    $display("test interrupt registers done");
    reset_check();
    results();
  end

endmodule // phy_mgmt_register_map_tb

bind pmr_core pmr_core_properties i_props (
  .clock(clock), .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .strap_pins(strap_pins), .an_restart_done(an_restart_done), .ctrl_out(ctrl_out),
  .soft_reset(soft_reset), .station_addr(station_addr)
);

`default_nettype wire
